/* File: rtl/dsi_defs.svh */
`ifndef DSI_DEFS_SVH
`define DSI_DEFS_SVH

// Register indices; byte address is four times the index
`define DSI_IDX_WARN 10'h0CB
`define DSI_IDX_PWR 10'h0CC
`define DSI_IDX_ILK 10'h0CD
`define DSI_IDX_CMD 10'h0CE
`define DSI_IDX_CFG 10'h0CF
// Register byte addresses
`define DSI_ADDR_WARN {`DSI_IDX_WARN, 2'h0}
`define DSI_ADDR_PWR {`DSI_IDX_PWR, 2'h0}
`define DSI_ADDR_ILK {`DSI_IDX_ILK, 2'h0}
`define DSI_ADDR_CMD {`DSI_IDX_CMD, 2'h0}
`define DSI_ADDR_CFG {`DSI_IDX_CFG, 2'h0}
// Command register bits
`define DSI_CMD_MODE0 0
`define DSI_CMD_MODE2 2
`define DSI_CMD_BUS_EN 4
`define DSI_CMD_FAULT_RST 8
`define DSI_CMD_WARN_RST 9
`define DSI_CMD_PM_LO 10
`define DSI_CMD_PM_HI 12
// Warning bits
`define DSI_WRN_RAIL 13
`define DSI_CYCLE_CLOCK_SYNC_WARNING 14
`define DSI_WRN_FIBRE 15
// Power status bits
`define DSI_PWR_SHOOT 6
`define DSI_PWR_GATE 7
`define DSI_PWR_OT 12
`define DSI_PWR_SHARE_LO 13
// Interlock bits
`define DSI_ILK_PARAMS 0
`define DSI_ILK_GAINS 1
`define DSI_ILK_PERMIT 2
`define DSI_ILK_FAULTS 3
`define DSI_ILK_EDGE 4
`define DSI_ILK_MULTI 5
`define DSI_ILK_BUS 6
`define DSI_ILK_CONTACTOR 7
`define DSI_ILK_GATE_MOD 8
`define DSI_ILK_BACKPLANE 9
// Reset values
`define DSI_REG_RESET 16'h0000
`define DSI_CMD_RESET 16'h0000
`endif

/* File: rtl/dsi_pkg.sv */
package dsi_pkg;
    typedef enum logic {
        DSI_CFG_VECTOR,
        DSI_CFG_PARALLEL
    } dsi_config_t;
endpackage

/* File: rtl/dsi_status_regs.sv */
`timescale 1ns/1ps
`include "dsi_defs.svh"
module dsi_status_regs #(
    parameter int ILK_W = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link and rail events
    input wire logic rail_comm_error,
    input wire logic cycle_clock_mismatch,
    input wire logic fibre_msg_done,
    input wire logic fibre_msg_error,
    // Module A trips, index U,V,W
    input wire logic [2:0] upper_trip,
    input wire logic [2:0] lower_trip,
    input wire logic overcurrent_trip,
    input wire logic shoot_through_trip,
    input wire logic gate_supply_fault,
    input wire logic module_a_overtemp,
    input wire logic [2:0] share_fault,
    input wire logic high_power_module,
    // Interlock conditions
    input wire logic params_bad,
    input wire logic gains_bad,
    input wire logic run_permit_input,
    input wire logic faults_pending,
    input wire logic bus_ready,
    input wire logic sync_aligned,
    input wire logic torque_loop_on,
    input wire logic contactor_failed,
    input wire logic gate_modules_mismatch,
    input wire logic bridge_test_start,
    input wire logic [2:0] modules_present,
    input wire logic backplane_bad,
    // Drive outputs
    output logic drive_fault,
    output logic torque_loop_enable,
    output logic [15:0] drive_command
);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic wr_en;
    logic rd_en;
    logic [15:0] warn_reg;
    logic [15:0] pwr_reg;
    logic [15:0] ilk_reg;
    logic [15:0] cmd_reg;
    logic [15:0] cmd_prev_reg;
    dsi_pkg::dsi_config_t cfg_reg;
    logic fibre_err_prev_reg;
    logic turn_on_reg;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == `DSI_ADDR_WARN) || (a == `DSI_ADDR_PWR) || (a == `DSI_ADDR_ILK)
            || (a == `DSI_ADDR_CMD) || (a == `DSI_ADDR_CFG);
    endfunction

    assign pslverr = psel && penable && !addr_known(paddr);

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= `DSI_CMD_RESET;
            cfg_reg <= dsi_pkg::DSI_CFG_VECTOR;
        end else if (wr_en && paddr == `DSI_ADDR_CMD) begin
            cmd_reg <= pwdata[15:0];
        end else if (wr_en && paddr == `DSI_ADDR_CFG) begin
            cfg_reg <= pwdata[0] ? dsi_pkg::DSI_CFG_PARALLEL : dsi_pkg::DSI_CFG_VECTOR;
        end
    end

    assign drive_command = cmd_reg;

    // ----------------------------------------
    // Warning word
    // ----------------------------------------
    logic [15:0] warn_set;
    always_comb begin
        warn_set = 16'h0000;
        warn_set[`DSI_WRN_RAIL] = rail_comm_error;
        warn_set[`DSI_CYCLE_CLOCK_SYNC_WARNING] = cycle_clock_mismatch;
        warn_set[`DSI_WRN_FIBRE] = fibre_msg_done && fibre_msg_error;
    end

    // Set wins over warning reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_reg <= `DSI_REG_RESET;
        end else if (cmd_reg[`DSI_CMD_WARN_RST]) begin
            warn_reg <= warn_set;
        end else begin
            warn_reg <= warn_reg | warn_set;
        end
    end

    // Consecutive message errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fibre_err_prev_reg <= 1'b0;
            drive_fault <= 1'b0;
        end else begin
            if (fibre_msg_done) begin
                fibre_err_prev_reg <= fibre_msg_error;
            end
            if (fibre_msg_done && fibre_msg_error && fibre_err_prev_reg) begin
                drive_fault <= 1'b1;
            end else if (cmd_reg[`DSI_CMD_FAULT_RST]) begin
                drive_fault <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Power module A status
    // ----------------------------------------
    logic [15:0] pwr_next;
    logic any_trip;
    always_comb begin
        any_trip = overcurrent_trip || shoot_through_trip;
        pwr_next = 16'h0000;
        pwr_next[2:0] = any_trip ? upper_trip : 3'h0;
        pwr_next[5:3] = any_trip ? lower_trip : 3'h0;
        pwr_next[`DSI_PWR_SHOOT] = shoot_through_trip;
        if (high_power_module) begin
            pwr_next[`DSI_PWR_GATE] = gate_supply_fault;
            pwr_next[`DSI_PWR_OT] = module_a_overtemp;
            pwr_next[15:13] = share_fault;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg <= `DSI_REG_RESET;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // ----------------------------------------
    // Interlock checks
    // ----------------------------------------
    logic checks_on;
    logic cmd_rise;
    logic [2:0] mode_bits;
    logic pm_select_bad;
    logic [15:0] cond;
    logic [15:0] ilk_next;
    logic found;
    logic [15:0] onset_now;
    logic [15:0] onset_hold_reg;
    logic [15:0] onset_fail;

    assign mode_bits = cmd_reg[`DSI_CMD_MODE2:`DSI_CMD_MODE0];
    assign checks_on = |mode_bits || cmd_reg[`DSI_CMD_BUS_EN];
    assign cmd_rise = |(cmd_reg & ~cmd_prev_reg);
    assign pm_select_bad = ~|(cmd_reg[`DSI_CMD_PM_HI:`DSI_CMD_PM_LO] & modules_present);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_prev_reg <= `DSI_CMD_RESET;
            turn_on_reg <= 1'b0;
        end else begin
            // Fault reset forces commands to be re-armed
            cmd_prev_reg <= cmd_reg[`DSI_CMD_FAULT_RST] ? 16'hFFFF : cmd_reg;
            turn_on_reg <= checks_on;
        end
    end

    // Checks made only in the first cycle of a turn-on
    always_comb begin
        onset_now = 16'h0000;
        onset_now[`DSI_ILK_EDGE] = !cmd_rise;
        onset_now[`DSI_ILK_BUS] = !(cmd_reg[`DSI_CMD_BUS_EN] && bus_ready);
        onset_now[`DSI_ILK_GATE_MOD] = gate_modules_mismatch;
    end

    // Turn-on results held while commands stay on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            onset_hold_reg <= `DSI_REG_RESET;
        end else if (!checks_on) begin
            onset_hold_reg <= `DSI_REG_RESET;
        end else if (!turn_on_reg) begin
            onset_hold_reg <= onset_now;
        end
    end

    assign onset_fail = turn_on_reg ? onset_hold_reg : onset_now;

    always_comb begin
        cond = 16'h0000;
        cond[`DSI_ILK_PARAMS] = params_bad;
        cond[`DSI_ILK_GAINS] = gains_bad;
        cond[`DSI_ILK_PERMIT] = !run_permit_input;
        cond[`DSI_ILK_FAULTS] = faults_pending;
        cond[`DSI_ILK_EDGE] = onset_fail[`DSI_ILK_EDGE];
        cond[`DSI_ILK_MULTI] = (mode_bits & (mode_bits - 3'h1)) != 3'h0;
        if (cfg_reg == dsi_pkg::DSI_CFG_VECTOR) begin
            cond[`DSI_ILK_BUS] = onset_fail[`DSI_ILK_BUS];
        end else begin
            cond[`DSI_ILK_BUS] = torque_loop_on && !sync_aligned;
        end
        cond[`DSI_ILK_CONTACTOR] = contactor_failed;
        cond[`DSI_ILK_GATE_MOD] = onset_fail[`DSI_ILK_GATE_MOD]
            || (bridge_test_start && pm_select_bad);
        cond[`DSI_ILK_BACKPLANE] = backplane_bad;
        // Lowest numbered problem only
        ilk_next = 16'h0000;
        found = 1'b0;
        for (int i = 0; i < ILK_W; i++) begin
            if (cond[i] && !found) begin
                ilk_next[i] = 1'b1;
                found = 1'b1;
            end
        end
    end

    // Result clears while checks are off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ilk_reg <= `DSI_REG_RESET;
        end else if (checks_on) begin
            ilk_reg <= ilk_next;
        end else begin
            ilk_reg <= `DSI_REG_RESET;
        end
    end

    assign torque_loop_enable = checks_on && turn_on_reg && (ilk_reg == 16'h0000);

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `DSI_ADDR_WARN: prdata <= {16'h0000, warn_reg};
                `DSI_ADDR_PWR: prdata <= {16'h0000, pwr_reg};
                `DSI_ADDR_ILK: prdata <= {16'h0000, ilk_reg};
                `DSI_ADDR_CMD: prdata <= {16'h0000, cmd_reg};
                `DSI_ADDR_CFG: prdata <= {31'h00000000, cfg_reg == dsi_pkg::DSI_CFG_PARALLEL};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

/* File: verification/dsi_status_regs_assertions.sv */
`timescale 1ns/1ps
`include "dsi_defs.svh"
module dsi_status_regs_checker (
    // Clock, reset, APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Events and conditions
    input wire logic rail_comm_error,
    input wire logic cycle_clock_mismatch,
    input wire logic fibre_msg_done,
    input wire logic fibre_msg_error,
    input wire logic shoot_through_trip,
    input wire logic high_power_module,
    input wire logic params_bad,
    // Drive outputs
    input wire logic drive_fault,
    input wire logic torque_loop_enable,
    input wire logic [15:0] drive_command
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_s;
    logic bad_msg;
    assign rd_s = psel && !penable && !pwrite;
    assign bad_msg = fibre_msg_done && fibre_msg_error;
    rail_warn_a: assert property (rd_s && paddr == `DSI_ADDR_WARN
        && $past(presetn) && $past(presetn, 2) && $past(rail_comm_error, 2)
        && !$past(drive_command[9]) |=> prdata[13]) else $error("rail warning missing");
    clock_warn_a: assert property (rd_s && paddr == `DSI_ADDR_WARN
        && $past(presetn) && $past(presetn, 2) && $past(cycle_clock_mismatch, 2)
        && !$past(drive_command[9]) |=> prdata[14]) else $error("clock warning missing");
    fault_cause_a: assert property (!drive_fault && !bad_msg |=> !drive_fault)
        else $error("fault without bad message");
    fault_pair_a: assert property (bad_msg ##1 !fibre_msg_done ##1 bad_msg
        |=> drive_fault) else $error("double error not escalated");
    torque_block_a: assert property (params_bad && drive_command[0]
        |=> !torque_loop_enable) else $error("torque loop runs with interlock");
    torque_cmd_a: assert property (!(|{drive_command[4], drive_command[2:0]}) [*2]
        |-> !torque_loop_enable) else $error("torque loop without command");
    cmd_write_a: assert property (psel && penable && pwrite && paddr == `DSI_ADDR_CMD
        |=> drive_command == $past(pwdata[15:0])) else $error("command write lost");
    unmapped_err_a: assert property (psel && penable
        && !(paddr inside {`DSI_ADDR_WARN, `DSI_ADDR_PWR, `DSI_ADDR_ILK, `DSI_ADDR_CMD,
        `DSI_ADDR_CFG}) |-> pslverr) else $error("unmapped access accepted");
    shoot_flag_a: assert property (rd_s && paddr == `DSI_ADDR_PWR && $past(presetn)
        |=> prdata[6] == $past(shoot_through_trip, 2)) else $error("shoot flag wrong");
    medium_bits_a: assert property (rd_s && paddr == `DSI_ADDR_PWR && $past(presetn)
        && !$past(high_power_module) |=> prdata[15:7] == 9'h000) else $error("medium bits set");
endmodule
bind dsi_status_regs dsi_status_regs_checker chk_u (.*);

/* File: verification/dsi_status_regs_tb.sv */
`timescale 1ns/1ps
`include "dsi_defs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, e); end end
module dsi_status_regs_tb;
    // ----
    // Signals and design
    // ----
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, drive_fault, torque_loop_enable;
    logic [15:0] drive_command;
    logic rail_comm_error = 1'h0, cycle_clock_mismatch = 1'h0;
    logic fibre_msg_done = 1'h0, fibre_msg_error = 1'h0;
    logic [2:0] upper_trip = '0, lower_trip = '0, share_fault = '0, modules_present = 3'h1;
    logic overcurrent_trip = 1'h0, shoot_through_trip = 1'h0, gate_supply_fault = 1'h0;
    logic module_a_overtemp = 1'h0, high_power_module = 1'h0, bus_ready = 1'h1;
    logic sync_aligned = 1'h1, torque_loop_on = 1'h0, gate_modules_mismatch = 1'h0;
    logic bridge_test_start = 1'h0;
    logic params_bad, gains_bad, run_permit_input, faults_pending, contactor_failed, backplane_bad;
    logic [5:0] pb = '0;
    int n_mismatch = 0, n_compared = 0;
    int idx[6] = '{0, 1, 2, 3, 7, 9};
    assign {backplane_bad, contactor_failed, faults_pending, run_permit_input, gains_bad,
        params_bad} = pb ^ 6'h04;
    dsi_status_regs dut_u (.*);
    always #5 pclk = ~pclk;
    // ----
    // Tasks
    // ----
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, '0);
        `CHK(rd, e)
    endtask
    task automatic turn_on(input logic [15:0] c, input logic [31:0] e);
        apb(1'h1, `DSI_ADDR_CMD, '0);
        apb(1'h1, `DSI_ADDR_CMD, {16'h0000, c});
        rchk(`DSI_ADDR_ILK, e);
    endtask
    task automatic ev(input logic [3:0] v, input int n);
        @(posedge pclk);
        {fibre_msg_error, fibre_msg_done, cycle_clock_mismatch, rail_comm_error} <= v;
        repeat (n) @(posedge pclk);
        {fibre_msg_error, fibre_msg_done, cycle_clock_mismatch, rail_comm_error} <= '0;
    endtask
    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----
    // Tests
    // ----
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rchk(`DSI_ADDR_PWR, '0);
        apb(1'h1, `DSI_ADDR_WARN, 32'h0000FFFF);
        rchk(`DSI_ADDR_WARN, '0);
        rchk(12'h3F0, '0);
        `CHK(err, 1'h1)
        ev(4'h1, 2);
        rchk(`DSI_ADDR_WARN, 32'h00002000);
        ev(4'h2, 2);
        rchk(`DSI_ADDR_WARN, 32'h00006000);
        ev(4'hC, 1);
        rchk(`DSI_ADDR_WARN, 32'h0000E000);
        apb(1'h1, `DSI_ADDR_CMD, 32'h00000200);
        apb(1'h1, `DSI_ADDR_CMD, '0);
        rchk(`DSI_ADDR_WARN, '0);
        ev(4'h4, 1);
        ev(4'hC, 1);
        ev(4'h4, 1);
        ev(4'hC, 1);
        @(negedge pclk);
        `CHK(drive_fault, 1'h0)
        ev(4'hC, 1);
        @(negedge pclk);
        `CHK(drive_fault, 1'h1)
        apb(1'h1, `DSI_ADDR_CMD, 32'h00000100);
        // Fault clears one edge after the command lands
        @(posedge pclk);
        @(negedge pclk);
        `CHK(drive_fault, 1'h0)
        apb(1'h1, `DSI_ADDR_CMD, 32'h00000011);
        rchk(`DSI_ADDR_ILK, 32'h00000010);
        turn_on(16'h0011, '0);
        `CHK(torque_loop_enable, 1'h1)
        `CHK(drive_command, 16'h0011)
        for (int i = 0; i < 6; i++) begin
            pb <= 6'h3F << i;
            rchk(`DSI_ADDR_ILK, 32'h1 << idx[i]);
            `CHK(torque_loop_enable, 1'h0)
        end
        apb(1'h1, `DSI_ADDR_CMD, '0);
        rchk(`DSI_ADDR_ILK, '0);
        pb <= '0;
        turn_on(16'h0013, 32'h00000020);
        turn_on(16'h0001, 32'h00000040);
        bus_ready <= 1'h0;
        turn_on(16'h0011, 32'h00000040);
        bus_ready <= 1'h1;
        gate_modules_mismatch <= 1'h1;
        turn_on(16'h0011, 32'h00000100);
        gate_modules_mismatch <= 1'h0;
        bridge_test_start <= 1'h1;
        turn_on(16'h0011, 32'h00000100);
        turn_on(16'h0411, '0);
        bridge_test_start <= 1'h0;
        apb(1'h1, `DSI_ADDR_CFG, 32'h00000001);
        torque_loop_on <= 1'h1;
        sync_aligned <= 1'h0;
        turn_on(16'h0011, 32'h00000040);
        for (int i = 0; i < 6; i++) begin
            {lower_trip, upper_trip} <= 6'h01 << i;
            overcurrent_trip <= 1'h1;
            rchk(`DSI_ADDR_PWR, 32'h1 << i);
        end
        overcurrent_trip <= 1'h0;
        shoot_through_trip <= 1'h1;
        rchk(`DSI_ADDR_PWR, 32'h00000060);
        {shoot_through_trip, gate_supply_fault, module_a_overtemp, share_fault} <= 6'h3F;
        high_power_module <= 1'h1;
        rchk(`DSI_ADDR_PWR, 32'h0000F0E0);
        high_power_module <= 1'h0;
        rchk(`DSI_ADDR_PWR, 32'h00000060);
        close_out();
    end
endmodule
